// ===== src/mpss_debounce.sv
`include "mpss_regs.svh"

module mpss_debounce #(
	parameter int CYCLES = `MPSS_DEBOUNCE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic raw_i,
	output logic level_o,
	output logic rise_o
);
	typedef struct packed
	{
		logic level;
		logic rise;
		logic [31:0] cnt;
	} mpss_db_t;

	mpss_db_t st_r;
	mpss_db_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rise = 1'b0;
		if (raw_i == st_r.level)
		begin
			st_nxt.cnt = 32'h0000_0000;
		end
		else if (st_r.cnt >= 32'(CYCLES - 1))
		begin
			st_nxt.level = raw_i;
			st_nxt.rise = raw_i;
			st_nxt.cnt = 32'h0000_0000;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign level_o = st_r.level;
	assign rise_o = st_r.rise;
endmodule

// ===== src/mpss_pkg.sv
package mpss_pkg;
	typedef enum logic [2:0]
	{
		MPSS_OFF,
		MPSS_PWRUP,
		MPSS_ON,
		MPSS_SLEEP,
		MPSS_SHDN_REQ,
		MPSS_PWRDN
	} mpss_state_t;
endpackage

// ===== src/mpss_regs.svh
// Contract
// - Carrier keeps supplies off until module releases reset; release means ready to boot.
// - Module drives shutdown request low on thermal, software or under-voltage need.
// - After supply-good enable falls, module asserts reset before carrier cuts supplies.
// - Exactly three main states OFF, ON, SLEEP, moved by hardware or software events.
// - OFF to ON only on rising supply-good enable with input supply present.
// - OFF is default, entered only from ON on an OFF event.
// - Supply-good enable low for 100 us while ON starts shutdown sequence.
// - Software shutdown only in ON with software running; thermal shutdown from any state (code acts on thermal only in ON and SLEEP).
// - All shutdowns drive request low; supply shutdown waits for supply-good enable low.
// - Supply-good enable is debounced with a 1 ms interval.
// - SLEEP, with deep sleep, entered only from ON; wake skips full boot.
// - Outputs hold their pre-sleep levels throughout SLEEP.
// - SLEEP left only on a wake event, internal or from connector pins; code also leaves SLEEP for the shutdown request state on thermal_unsafe_i.
// - Timer programmed at sleep entry wakes the module on expiry.
// - Crossing hot or cold limit during SLEEP forces wake.
// - USB supply, card detect and connector wakes are individually enabled.
// - Reset line assertion resets module and onboard storage; code acts on it only in ON, not in SLEEP or the shutdown request state.
// - Sleep indicator low while in deep sleep sub-mode.
// - Reset line is open-drain; carrier may pull low, module releases after sequence.
`ifndef MPSS_REGS_SVH
`define MPSS_REGS_SVH

`define MPSS_CLK_HZ 20_000_000
`define MPSS_DEBOUNCE_US 1000
`define MPSS_HW_SHDN_US 100
`define MPSS_DEBOUNCE_CYC ((`MPSS_DEBOUNCE_US * (`MPSS_CLK_HZ / 1_000_000)))
`define MPSS_HW_SHDN_CYC ((`MPSS_HW_SHDN_US * (`MPSS_CLK_HZ / 1_000_000)))
`define MPSS_PWRUP_CYC 16
`define MPSS_PWRDN_CYC 16
`define MPSS_WAKE_TIMER_W 32
`define MPSS_WAKE_PIN_N 4
`define MPSS_OUT_W 8
`define MPSS_WK_USB 0
`define MPSS_WK_CARD 1

`endif

// ===== src/mpss_sequencer.sv
`include "mpss_regs.svh"

module mpss_sequencer #(
	parameter int DEBOUNCE_CYC = `MPSS_DEBOUNCE_CYC,
	parameter int HW_SHDN_CYC = `MPSS_HW_SHDN_CYC,
	parameter int PWRUP_CYC = `MPSS_PWRUP_CYC,
	parameter int PWRDN_CYC = `MPSS_PWRDN_CYC,
	parameter int OUT_W = `MPSS_OUT_W,
	parameter int WAKE_PIN_N = `MPSS_WAKE_PIN_N,
	parameter int TIMER_W = `MPSS_WAKE_TIMER_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic supply_good_en_i,
	input wire logic input_supply_ok_i,
	input wire logic module_reset_n_i,
	output logic module_reset_n_o,
	output logic module_reset_n_oe_o,
	output logic shutdown_req_n_o,
	output logic sleep_indicator_n_o,
	output logic storage_reset_o,
	output logic [2:0] power_state_o,
	input wire logic sw_running_i,
	input wire logic sw_shutdown_i,
	input wire logic undervoltage_i,
	input wire logic thermal_unsafe_i,
	input wire logic temp_hot_i,
	input wire logic temp_cold_i,
	input wire logic sleep_req_i,
	input wire logic deep_sleep_level_i,
	input wire logic [TIMER_W-1:0] wake_timer_i,
	input wire logic wake_timer_en_i,
	input wire logic usb_supply_detect_i,
	input wire logic card_detect_i,
	input wire logic [WAKE_PIN_N-1:0] wake_pin_i,
	input wire logic [1:0] wake_src_en_i,
	input wire logic [WAKE_PIN_N-1:0] wake_pin_en_i,
	input wire logic [OUT_W-1:0] live_out_i,
	output logic [OUT_W-1:0] held_out_o
);
	typedef struct packed
	{
		mpss_pkg::mpss_state_t state;
		logic [31:0] cnt;
		logic [TIMER_W-1:0] timer;
		logic timer_on;
		logic deep;
		logic req_n;
		logic rst_drive;
		logic sleep_n;
		logic stor_rst;
		logic [OUT_W-1:0] held;
		logic [2:0] pstate;
	} mpss_seq_t;

	mpss_seq_t st_r;
	mpss_seq_t st_nxt;
	logic en_level;
	logic en_rise;
	logic wake;
	logic shdn_need;

	mpss_debounce #(
		.CYCLES(DEBOUNCE_CYC)
	) u_debounce (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.raw_i(supply_good_en_i),
		.level_o(en_level),
		.rise_o(en_rise)
	);

	function automatic logic [1:0] state_code(input mpss_pkg::mpss_state_t s);
		case (s)
			mpss_pkg::MPSS_ON: state_code = 2'h1;
			mpss_pkg::MPSS_SLEEP: state_code = 2'h2;
			mpss_pkg::MPSS_SHDN_REQ: state_code = 2'h1;
			default: state_code = 2'h0;
		endcase
	endfunction

	// Terminal count shared by every timed phase
	function automatic logic cnt_done(input logic [31:0] cnt, input int lim);
		cnt_done = cnt >= 32'(lim - 1);
	endfunction

	function automatic logic [31:0] cnt_inc(input logic [31:0] cnt);
		cnt_inc = cnt + 32'h0000_0001;
	endfunction

	always_comb
	begin
		wake = (usb_supply_detect_i & wake_src_en_i[`MPSS_WK_USB])
			| (card_detect_i & wake_src_en_i[`MPSS_WK_CARD])
			| (|(wake_pin_i & wake_pin_en_i))
			| (st_r.timer_on && st_r.timer == '0)
			| temp_hot_i | temp_cold_i;
		shdn_need = thermal_unsafe_i | undervoltage_i | (sw_shutdown_i & sw_running_i);
	end

	always_comb
	begin
		st_nxt = st_r;
		case (st_r.state)
			mpss_pkg::MPSS_OFF:
			begin
				st_nxt.rst_drive = 1'b1;
				st_nxt.stor_rst = 1'b1;
				st_nxt.req_n = 1'b1;
				st_nxt.sleep_n = 1'b1;
				st_nxt.cnt = '0;
				if (en_rise && input_supply_ok_i)
				begin
					st_nxt.state = mpss_pkg::MPSS_PWRUP;
				end
			end
			mpss_pkg::MPSS_PWRUP:
			begin
				st_nxt.cnt = cnt_inc(st_r.cnt);
				if (!en_level)
				begin
					st_nxt.state = mpss_pkg::MPSS_OFF;
				end
				else if (cnt_done(st_r.cnt, PWRUP_CYC))
				begin
					st_nxt.rst_drive = 1'b0;
					st_nxt.stor_rst = 1'b0;
					st_nxt.cnt = '0;
					st_nxt.state = mpss_pkg::MPSS_ON;
				end
			end
			mpss_pkg::MPSS_ON:
			begin
				st_nxt.held = live_out_i;
				st_nxt.sleep_n = 1'b1;
				// Raw low time counted; debounced level confirms
				if (!supply_good_en_i)
				begin
					st_nxt.cnt = cnt_inc(st_r.cnt);
				end
				else
				begin
					st_nxt.cnt = '0;
				end
				if (!en_level || cnt_done(st_r.cnt, HW_SHDN_CYC))
				begin
					st_nxt.req_n = 1'b0;
					st_nxt.cnt = '0;
					if (!en_level)
					begin
						st_nxt.state = mpss_pkg::MPSS_PWRDN;
					end
					else
					begin
						st_nxt.state = mpss_pkg::MPSS_SHDN_REQ;
					end
				end
				else if (shdn_need)
				begin
					st_nxt.req_n = 1'b0;
					st_nxt.state = mpss_pkg::MPSS_SHDN_REQ;
				end
				else if (sleep_req_i)
				begin
					st_nxt.deep = deep_sleep_level_i;
					st_nxt.sleep_n = ~deep_sleep_level_i;
					st_nxt.timer = wake_timer_i;
					st_nxt.timer_on = wake_timer_en_i;
					st_nxt.state = mpss_pkg::MPSS_SLEEP;
				end
			end
			mpss_pkg::MPSS_SLEEP:
			begin
				st_nxt.sleep_n = ~st_r.deep;
				if (st_r.timer_on && st_r.timer != '0)
				begin
					st_nxt.timer = st_r.timer - 1'b1;
				end
				if (thermal_unsafe_i)
				begin
					st_nxt.req_n = 1'b0;
					st_nxt.deep = 1'b0;
					st_nxt.sleep_n = 1'b1;
					st_nxt.state = mpss_pkg::MPSS_SHDN_REQ;
				end
				else if (wake)
				begin
					st_nxt.sleep_n = 1'b1;
					st_nxt.deep = 1'b0;
					st_nxt.timer_on = 1'b0;
					st_nxt.state = mpss_pkg::MPSS_ON;
				end
			end
			mpss_pkg::MPSS_SHDN_REQ:
			begin
				// Wait for carrier to drop enable
				st_nxt.req_n = 1'b0;
				st_nxt.cnt = '0;
				if (!en_level)
				begin
					st_nxt.state = mpss_pkg::MPSS_PWRDN;
				end
			end
			mpss_pkg::MPSS_PWRDN:
			begin
				st_nxt.rst_drive = 1'b1;
				st_nxt.stor_rst = 1'b1;
				st_nxt.cnt = cnt_inc(st_r.cnt);
				if (cnt_done(st_r.cnt, PWRDN_CYC))
				begin
					st_nxt.state = mpss_pkg::MPSS_OFF;
				end
			end
			default:
			begin
				st_nxt.state = mpss_pkg::MPSS_OFF;
			end
		endcase
		// Line goes low on the edge that enters PWRDN, never a cycle late
		if (st_nxt.state == mpss_pkg::MPSS_PWRDN)
		begin
			st_nxt.rst_drive = 1'b1;
			st_nxt.stor_rst = 1'b1;
		end
		// Carrier pulling the line low while ON resets module and storage
		if (!module_reset_n_i && !st_r.rst_drive && st_r.state == mpss_pkg::MPSS_ON)
		begin
			st_nxt.stor_rst = 1'b1;
			st_nxt.rst_drive = 1'b1;
			st_nxt.state = mpss_pkg::MPSS_PWRUP;
			st_nxt.cnt = '0;
		end
		// State code registered so the port comes straight from a flop
		st_nxt.pstate = {1'b0, state_code(st_nxt.state)};
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= '{state: mpss_pkg::MPSS_OFF, cnt: '0, timer: '0, timer_on: 1'b0,
				deep: 1'b0, req_n: 1'b1, rst_drive: 1'b1, sleep_n: 1'b1,
				stor_rst: 1'b1, held: '0, pstate: 3'h0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Open drain: only ever drives low
	assign module_reset_n_o = 1'b0;
	assign module_reset_n_oe_o = st_r.rst_drive;
	assign shutdown_req_n_o = st_r.req_n;
	assign sleep_indicator_n_o = st_r.sleep_n;
	assign storage_reset_o = st_r.stor_rst;
	assign power_state_o = st_r.pstate;
	assign held_out_o = st_r.held;
endmodule

// ===== verif/mpss_carrier.sv
module mpss_carrier (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic on_i,
	input wire logic pull_i,
	input wire logic drv_i,
	input wire logic [3:0] lag_i,
	input wire logic oe_i,
	input wire logic req_n_i,
	output logic en_o,
	output logic ok_o,
	output logic line_o,
	output logic sup_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	logic shut_r;
	// Pull-up wins only when nobody pulls the line
	assign line_o = !pull_i && (oe_i ? drv_i : 1'b1);
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			{en_o, ok_o, sup_o, shut_r, cnt_r} <= 8'h00;
		end
		else
		begin
			ok_o <= on_i;
			// Supplies and I/O drive follow the released line
			sup_o <= line_o;
			if (!req_n_i)
			begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r >= lag_i)
					shut_r <= 1'b1;
			end
			else
			begin
				cnt_r <= 4'h0;
				if (!on_i)
					shut_r <= 1'b0;
			end
			// Sticky shut keeps enable low once serviced
			en_o <= on_i && ok_o && !shut_r;
		end
	end
endmodule

// ===== verif/mpss_sequencer_chk.sv
module mpss_sequencer_chk #(
	parameter int OUT_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic module_reset_n_i,
	input wire logic module_reset_n_oe_o,
	input wire logic shutdown_req_n_o,
	input wire logic sleep_indicator_n_o,
	input wire logic storage_reset_o,
	input wire logic [2:0] power_state_o,
	input wire logic thermal_unsafe_i,
	input wire logic deep_sleep_level_i,
	input wire logic [OUT_W-1:0] held_out_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_off_rst; power_state_o == 3'h0 |-> module_reset_n_oe_o; endproperty
	a_off_rst: assert property (p_off_rst) else $error("line released in off");
	property p_rel_on; $fell(module_reset_n_oe_o) |-> power_state_o == 3'h1; endproperty
	a_rel_on: assert property (p_rel_on) else $error("release outside on");
	property p_slp_from; power_state_o == 3'h2 |-> $past(power_state_o) inside {3'h1, 3'h2};
	endproperty
	a_slp_from: assert property (p_slp_from) else $error("sleep not from on");
	property p_hold; power_state_o == 3'h2 && $past(power_state_o) == 3'h2 |-> $stable(held_out_o);
	endproperty
	a_hold: assert property (p_hold) else $error("outputs moved in sleep");
	property p_deep; $rose(power_state_o == 3'h2) |->
		sleep_indicator_n_o == !$past(deep_sleep_level_i); endproperty
	a_deep: assert property (p_deep) else $error("sleep indicator wrong");
	property p_req; power_state_o == 3'h1 && thermal_unsafe_i |->
		##[1:3] (!shutdown_req_n_o || power_state_o == 3'h0); endproperty
	a_req: assert property (p_req) else $error("no shutdown request");
	property p_thm; power_state_o == 3'h2 && thermal_unsafe_i |-> ##[1:3] !shutdown_req_n_o;
	endproperty
	a_thm: assert property (p_thm) else $error("no thermal request in sleep");
	property p_sto; !module_reset_n_i |-> ##[0:3] storage_reset_o; endproperty
	a_sto: assert property (p_sto) else $error("storage not reset");
endmodule
bind mpss_sequencer mpss_sequencer_chk #(.OUT_W(OUT_W)) chk_inst (.ref_clk_i, .rst_i,
	.module_reset_n_i, .module_reset_n_oe_o, .shutdown_req_n_o, .sleep_indicator_n_o,
	.storage_reset_o, .power_state_o, .thermal_unsafe_i, .deep_sleep_level_i, .held_out_o);

// ===== verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, rst_i, supply_good_en_i, input_supply_ok_i, module_reset_n_i;
	logic module_reset_n_oe_o, shutdown_req_n_o, sleep_indicator_n_o, storage_reset_o;
	logic sw_running_i, sw_shutdown_i, undervoltage_i, thermal_unsafe_i, temp_hot_i;
	logic temp_cold_i, sleep_req_i, deep_sleep_level_i, wake_timer_en_i;
	logic usb_supply_detect_i, card_detect_i, on_cmd, pull, sup, module_reset_n_o;
	logic [2:0] power_state_o;
	logic [31:0] wake_timer_i;
	logic [3:0] wake_pin_i, wake_pin_en_i;
	logic [1:0] wake_src_en_i;
	logic [7:0] live_out_i, held_out_o;
	int fails, checks_done;
	// Short counts keep the run brief
	mpss_sequencer #(.DEBOUNCE_CYC(8), .HW_SHDN_CYC(4)) mpss_sequencer_inst (.ref_clk_i, .rst_i,
		.supply_good_en_i, .input_supply_ok_i, .module_reset_n_i, .module_reset_n_o,
		.module_reset_n_oe_o, .shutdown_req_n_o, .sleep_indicator_n_o, .storage_reset_o,
		.power_state_o, .sw_running_i, .sw_shutdown_i, .undervoltage_i, .thermal_unsafe_i,
		.temp_hot_i, .temp_cold_i, .sleep_req_i, .deep_sleep_level_i, .wake_timer_i,
		.wake_timer_en_i, .usb_supply_detect_i, .card_detect_i, .wake_pin_i, .wake_src_en_i,
		.wake_pin_en_i, .live_out_i, .held_out_o);
	mpss_carrier mpss_carrier_inst (.ref_clk_i, .rst_i, .on_i(on_cmd), .pull_i(pull),
		.drv_i(module_reset_n_o), .lag_i(4'h5), .oe_i(module_reset_n_oe_o),
		.req_n_i(shutdown_req_n_o),
		.en_o(supply_good_en_i), .ok_o(input_supply_ok_i), .line_o(module_reset_n_i), .sup_o(sup));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	task step(int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task chk(string n, logic [7:0] s, logic [7:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wst(logic [2:0] s);
		int i;
		for (i = 0; i < 300 && power_state_o !== s; i++)
			step(1);
		if (power_state_o !== s)
		begin
			fails++;
			complete_run();
		end
	endtask
	task t_up();
		on_cmd = 1'b1;
		step(20);
		chk("state", power_state_o, 3'h0);
		chk("sup", sup, 1'b0);
		wst(3'h1);
		chk("oe", module_reset_n_oe_o, 1'b0);
		chk("sto", storage_reset_o, 1'b0);
		chk("req", shutdown_req_n_o, 1'b1);
		chk("rst_o", module_reset_n_o, 1'b0);
		$display("t_up done");
	endtask
	task t_pull();
		pull = 1'b1;
		step(4);
		chk("sto", storage_reset_o, 1'b1);
		pull = 1'b0;
		wst(3'h1);
		$display("t_pull done");
	endtask
	task t_sleep();
		{live_out_i, deep_sleep_level_i, wake_timer_en_i} = 10'h16b;
		wake_timer_i = 32'h0000_0014;
		sleep_req_i = 1'b1;
		step(1);
		sleep_req_i = 1'b0;
		wst(3'h2);
		chk("slp_n", sleep_indicator_n_o, 1'b0);
		live_out_i = 8'ha5;
		step(10);
		chk("held", held_out_o, 8'h5a);
		chk("state", power_state_o, 3'h2);
		wst(3'h1);
		step(2);
		chk("held", held_out_o, 8'ha5);
		chk("oe", module_reset_n_oe_o, 1'b0);
		chk("slp_n", sleep_indicator_n_o, 1'b1);
		$display("t_sleep done");
	endtask
	task t_wakes();
		int k;
		{deep_sleep_level_i, wake_timer_en_i} = 2'h0;
		for (k = 0; k < 5; k++)
		begin
			sleep_req_i = 1'b1;
			step(1);
			sleep_req_i = 1'b0;
			wst(3'h2);
			// Other gates open, so only a USB, card or pin source's own gate holds it off; hot and cold have no gate
			{wake_pin_en_i[1], wake_src_en_i} = ~(3'h1 << k);
			{temp_cold_i, temp_hot_i, wake_pin_i[1], card_detect_i, usb_supply_detect_i} =
				5'h01 << k;
			step(4);
			chk("gate", power_state_o, k > 2 ? 3'h1 : 3'h2);
			{wake_pin_en_i[1], wake_src_en_i} = 3'h1 << k;
			wst(3'h1);
			{temp_cold_i, temp_hot_i, wake_pin_i[1], card_detect_i, usb_supply_detect_i} =
				5'h00;
			{wake_pin_en_i[1], wake_src_en_i} = 3'h0;
			step(1);
		end
		$display("t_wakes done");
	endtask
	task t_shut();
		sw_shutdown_i = 1'b1;
		step(6);
		chk("sw_req", shutdown_req_n_o, 1'b1);
		sw_shutdown_i = 1'b0;
		sleep_req_i = 1'b1;
		step(1);
		sleep_req_i = 1'b0;
		wst(3'h2);
		thermal_unsafe_i = 1'b1;
		step(3);
		chk("req", shutdown_req_n_o, 1'b0);
		chk("oe", module_reset_n_oe_o, 1'b0);
		wst(3'h0);
		chk("oe", module_reset_n_oe_o, 1'b1);
		step(1);
		chk("sup", sup, 1'b0);
		{thermal_unsafe_i, on_cmd} = 2'h0;
		$display("t_shut done");
	endtask
	task t_down();
		step(24);
		on_cmd = 1'b1;
		wst(3'h1);
		chk("oe", module_reset_n_oe_o, 1'b0);
		{sw_running_i, sw_shutdown_i} = 2'h3;
		step(2);
		chk("sw_req", shutdown_req_n_o, 1'b0);
		chk("oe", module_reset_n_oe_o, 1'b0);
		{sw_running_i, sw_shutdown_i} = 2'h0;
		wst(3'h0);
		chk("oe", module_reset_n_oe_o, 1'b1);
		on_cmd = 1'b0;
		step(24);
		on_cmd = 1'b1;
		wst(3'h1);
		on_cmd = 1'b0;
		step(7);
		chk("hw_req", shutdown_req_n_o, 1'b0);
		chk("state", power_state_o, 3'h1);
		chk("oe", module_reset_n_oe_o, 1'b0);
		wst(3'h0);
		chk("oe", module_reset_n_oe_o, 1'b1);
		step(24);
		on_cmd = 1'b1;
		wst(3'h1);
		undervoltage_i = 1'b1;
		step(2);
		chk("uv_req", shutdown_req_n_o, 1'b0);
		undervoltage_i = 1'b0;
		wst(3'h0);
		chk("oe", module_reset_n_oe_o, 1'b1);
		$display("t_down done");
	endtask
	initial
	begin
		{on_cmd, pull, sw_running_i, sw_shutdown_i, undervoltage_i, thermal_unsafe_i} = 6'h00;
		{temp_hot_i, temp_cold_i, sleep_req_i, deep_sleep_level_i, wake_timer_en_i} = 5'h00;
		{usb_supply_detect_i, card_detect_i, wake_src_en_i, wake_pin_i} = 8'h00;
		{wake_pin_en_i, live_out_i, wake_timer_i} = 44'h000_0000_0000;
		fails = 0;
		checks_done = 0;
		rst_i = 1'b1;
		step(6);
		rst_i = 1'b0;
		t_up();
		t_pull();
		t_sleep();
		t_wakes();
		t_shut();
		t_down();
		complete_run();
	end
endmodule
